// ### hdl/lpcs_defs.svh
// Constants of the line printer character sequencer: offsets, fields, resets, timings.
// Assumes inclusion by bare name from the package and the design module.
`ifndef LPCS_DEFS_SVH
`define LPCS_DEFS_SVH

// Register byte offsets
`define LPCS_OFF_CTRL     4'h0
`define LPCS_OFF_DATA_LO  4'h4
`define LPCS_OFF_DATA_HI  4'h8
`define LPCS_OFF_SEQ      4'hC

// Control word: status fields in [8:0], init request in bit 9
`define LPCS_INIT_BIT     9
`define LPCS_ST_W         9
`define LPCS_ST_RESET     9'h000
// Sequence word fields
`define LPCS_SEQ_COL_LSB  0
`define LPCS_SEQ_FLG_LSB  8
`define LPCS_SEQ_CNT_LSB  14
`define LPCS_SEQ_RDY_BIT  17

// Character and shift counter figures
`define LPCS_CHAR_W       7
`define LPCS_NCHAR        5
`define LPCS_CNT_LAST     3'h4
`define LPCS_SPACE_CODE   7'h20
`define LPCS_TAB_CODE     7'h09

// Fixed delays in nanoseconds
`define LPCS_T_INIT_NS    1000
`define LPCS_T_LOAD_NS    2200
`define LPCS_T_STRB_NS    2500
`define LPCS_T_CYC_NS     4000
`define LPCS_T_ARM_NS     1000

// AXI responses
`define LPCS_RESP_OKAY    2'h0
`define LPCS_RESP_SLVERR  2'h2

`endif

// ### hdl/lpcs_pkg.sv
// Types of the line printer character sequencer.
// Assumes lpcs_defs.svh on the include path.
`include "lpcs_defs.svh"

package lpcs_pkg;

	// Status word as read back by software
	typedef struct packed {
		logic       err_en;
		logic       busy;
		logic       done;
		logic [2:0] irq_b;
		logic [2:0] irq_a;
	} lpcs_status_s;

	// Sequencing flags
	typedef struct packed {
		logic alternate;
		logic clear_pending;
		logic shift_ready_a;
		logic shift_ready_b;
		logic load_settled;
		logic forced_print;
	} lpcs_flags_s;

	// Character classes found by the decoder
	typedef enum logic [2:0] {
		CT_PRINT,
		CT_SPACE,
		CT_PSPACE,
		CT_HTAB,
		CT_ILLEGAL
	} lpcs_ctype_e;

endpackage : lpcs_pkg

// ### hdl/lpcs_sequencer.sv
// Line printer character sequencer: AXI4-Lite register slave, five-character
// shift buffer, character decoder, fixed-delay timers and printer handshake.
// Assumes one 50 MHz clock, synchronous active-low reset, asynchronous printer pins.
`timescale 1ns/100ps
`include "lpcs_defs.svh"

module lpcs_sequencer
	import lpcs_pkg::*;
#(
	parameter int CLK_MHZ = 50
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Printer mechanism
	input  wire logic        printer_ready,
	input  wire logic        printer_fault,
	output logic [6:0]       printer_data,
	output logic             printer_strobe,
	output logic             printer_space_cmd,
	output logic             printer_print_cmd,
	output logic             printer_memory_clear,
	// Interrupt channel requests, one line per channel
	output logic [7:1]       irq_channel_req
);

	localparam int NT     = 5;
	localparam int TW     = 16;
	localparam int BUF_W  = `LPCS_CHAR_W * `LPCS_NCHAR;
	localparam int T_INIT = 0;
	localparam int T_LOAD = 1;
	localparam int T_STRB = 2;
	localparam int T_CYC  = 3;
	localparam int T_ARM  = 4;

	// Least times round up to whole cycles, never below one
	function automatic int tcycles(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : tcycles

	function automatic int tsel(input int idx);
		int ns;
		ns = `LPCS_T_ARM_NS;
		case (idx)
			T_INIT:  ns = `LPCS_T_INIT_NS;
			T_LOAD:  ns = `LPCS_T_LOAD_NS;
			T_STRB:  ns = `LPCS_T_STRB_NS;
			T_CYC:   ns = `LPCS_T_CYC_NS;
			default: ns = `LPCS_T_ARM_NS;
		endcase
		return tcycles(ns);
	endfunction : tsel

	// Character class decode
	function automatic lpcs_ctype_e decode(input logic [6:0] c);
		if (c >= 7'h20 && c <= 7'h5F)
			return CT_PRINT;
		else if (c >= 7'h10 && c <= 7'h14)
			return CT_SPACE;
		else if (c >= 7'h0A && c <= 7'h0C)
			return CT_PSPACE;
		else if (c == `LPCS_TAB_CODE)
			return CT_HTAB;
		else
			return CT_ILLEGAL;
	endfunction : decode

	// Channel number to request line, zero means polled only
	function automatic logic [7:1] chan_line(input logic [2:0] ch, input logic req);
		logic [7:1] v;
		v = 7'h00;
		for (int i = 1; i <= 7; i++)
			if (req && ch == 3'(i))
				v[i] = 1'b1;
		return v;
	endfunction : chan_line

	initial begin
		if (CLK_MHZ < 1 || tcycles(`LPCS_T_CYC_NS) >= (1 << TW))
			$error("lpcs_sequencer: CLK_MHZ out of range");
	end

	lpcs_status_s     st_r;
	lpcs_flags_s      fl_r;
	logic [BUF_W-1:0] buf_r;
	logic [2:0]       cnt_r;
	logic [7:0]       col_r;
	logic [2:0]       hi_r;
	lpcs_ctype_e      ctype_r;
	logic [1:0]       rdy_sync_r;
	logic [1:0]       flt_sync_r;
	logic [NT-1:0]    t_start;
	logic [NT-1:0]    t_fire;
	logic [NT-1:0]    t_run;

	logic        wr_go;
	logic        control_out_instr_wr;
	logic        init_req;
	logic        data_out_instr_wr;
	logic        ready_s;
	logic        fault_s;
	logic        go;
	lpcs_ctype_e ctype;
	logic        tab_stop;
	logic        run_cycle;
	logic        advance;
	logic        completion;
	logic        tab_rearm;
	logic        int_strobe;

	// Pin inputs pass two flip-flops before use
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdy_sync_r <= 2'h0;
			flt_sync_r <= 2'h0;
		end else begin
			rdy_sync_r <= {rdy_sync_r[0], printer_ready};
			flt_sync_r <= {flt_sync_r[0], printer_fault};
		end
	end
	assign ready_s = rdy_sync_r[1];
	assign fault_s = flt_sync_r[1];

	// Address and data are taken together, so no half-write is ever held
	assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_wready  = s_axi_awready;
	assign s_axi_arready = ~s_axi_rvalid;
	assign wr_go    = s_axi_awready & (s_axi_wstrb == 4'hF);
	assign control_out_instr_wr  = wr_go & (s_axi_awaddr == `LPCS_OFF_CTRL);
	assign init_req = control_out_instr_wr & s_axi_wdata[`LPCS_INIT_BIT];
	assign data_out_instr_wr = wr_go & (s_axi_awaddr == `LPCS_OFF_DATA_LO);

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `LPCS_RESP_OKAY;
		end else if (s_axi_awready) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (s_axi_awaddr == `LPCS_OFF_SEQ) ? `LPCS_RESP_SLVERR
				: `LPCS_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read answer; all four word offsets are mapped, and a misaligned offset is answered with SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `LPCS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= (s_axi_araddr[1:0] != 2'h0) ? `LPCS_RESP_SLVERR
				: `LPCS_RESP_OKAY;
			unique case (s_axi_araddr[3:2])
				2'h0: s_axi_rdata <= {23'h000000, st_r};
				2'h1: s_axi_rdata <= buf_r[31:0];
				2'h2: s_axi_rdata <= {29'h00000000, hi_r};
				2'h3: s_axi_rdata <= {14'h0000, ready_s, cnt_r, fl_r, col_r};
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Upper three data bits are staged before the low word triggers the load
	always_ff @(posedge aclk) begin
		if (!aresetn)
			hi_r <= 3'h0;
		else if (wr_go && s_axi_awaddr == `LPCS_OFF_DATA_HI)
			hi_r <= s_axi_wdata[2:0];
	end

	// One delay counter per timed path; a new start restarts it
	generate
		for (genvar g = 0; g < NT; g++) begin : g_tmr
			logic [TW-1:0] tc_r;
			logic          run_r;
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					tc_r  <= '0;
					run_r <= 1'b0;
				end else if (t_start[g]) begin
					tc_r  <= TW'(tsel(g) - 1);
					run_r <= 1'b1;
				end else if (run_r) begin
					if (tc_r == '0)
						run_r <= 1'b0;
					else
						tc_r <= tc_r - 1'b1;
				end
			end
			assign t_fire[g] = run_r & (tc_r == '0);
			assign t_run[g]  = run_r;
		end
	endgenerate

	// Sequencing decisions
	assign ctype      = decode(buf_r[6:0]);
	assign tab_stop   = (col_r[2:0] == 3'h7);
	assign go         = fl_r.load_settled & fl_r.shift_ready_a & fl_r.shift_ready_b
		& ready_s;
	assign int_strobe = go & (ctype == CT_PRINT || ctype == CT_HTAB);
	assign run_cycle  = go & ~(ctype == CT_HTAB && !tab_stop);
	assign advance    = t_fire[T_CYC] & (cnt_r < `LPCS_CNT_LAST);
	// A stopping tab is re-armed by its own cycle; arming it here too would repeat it
	assign tab_rearm  = t_fire[T_STRB] & (ctype_r == CT_HTAB) & ~t_run[T_CYC];
	assign completion = (t_fire[T_CYC] & (cnt_r == `LPCS_CNT_LAST))
		| (fl_r.clear_pending & ready_s);

	assign t_start[T_INIT] = init_req;
	assign t_start[T_LOAD] = data_out_instr_wr;
	assign t_start[T_STRB] = int_strobe;
	assign t_start[T_CYC]  = run_cycle;
	assign t_start[T_ARM]  = advance | tab_rearm;

	// Status register; hardware completion is applied last so it wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= lpcs_status_s'(`LPCS_ST_RESET);
		end else begin
			if (control_out_instr_wr)
				st_r <= lpcs_status_s'(s_axi_wdata[`LPCS_ST_W-1:0]);
			if (t_fire[T_INIT]) begin
				st_r.busy <= 1'b1;
				st_r.done <= 1'b0;
			end
			if (data_out_instr_wr) begin
				st_r.busy <= 1'b1;
				st_r.done <= 1'b0;
			end
			if (completion) begin
				st_r.busy <= 1'b0;
				st_r.done <= 1'b1;
			end
		end
	end

	// Sequencing flags; later events in the same cycle take priority
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fl_r <= '0;
		end else begin
			if (init_req)
				fl_r <= '0;
			if (t_fire[T_INIT])
				fl_r.clear_pending <= 1'b1;
			if (fl_r.clear_pending && ready_s)
				fl_r.clear_pending <= 1'b0;
			if (data_out_instr_wr) begin
				fl_r.load_settled  <= 1'b0;
				fl_r.shift_ready_a <= 1'b1;
				fl_r.shift_ready_b <= 1'b1;
			end
			if (t_fire[T_LOAD])
				fl_r.load_settled <= 1'b1;
			if (go) begin
				fl_r.shift_ready_a <= 1'b0;
				fl_r.shift_ready_b <= 1'b0;
			end
			if (advance || tab_rearm)
				fl_r.shift_ready_b <= 1'b1;
			if (t_fire[T_ARM])
				fl_r.shift_ready_a <= 1'b1;
		end
	end

	// Shift buffer and shift counter; the top group is kept, not refilled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buf_r <= '0;
			cnt_r <= 3'h0;
		end else if (data_out_instr_wr) begin
			buf_r <= {hi_r, s_axi_wdata};
			cnt_r <= 3'h0;
		end else if (init_req) begin
			cnt_r <= `LPCS_CNT_LAST;
		end else if (advance) begin
			buf_r <= {buf_r[BUF_W-1 -: 7], buf_r[BUF_W-1:7]};
			cnt_r <= cnt_r + 3'h1;
		end
	end

	// Column counter
	always_ff @(posedge aclk) begin
		if (!aresetn)
			col_r <= 8'h00;
		else if (t_fire[T_INIT] || (go && ctype == CT_PSPACE))
			col_r <= 8'h00;
		else if (int_strobe)
			col_r <= col_r + 8'h01;
	end

	// Printer outputs: data latched at go, commands as one-cycle pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctype_r              <= CT_ILLEGAL;
			printer_data         <= 7'h00;
			printer_strobe       <= 1'b0;
			printer_space_cmd    <= 1'b0;
			printer_print_cmd    <= 1'b0;
			printer_memory_clear <= 1'b0;
		end else begin
			printer_strobe       <= t_fire[T_STRB]
				& (ctype_r == CT_PRINT || ctype_r == CT_HTAB);
			printer_space_cmd    <= go & (ctype == CT_SPACE);
			printer_print_cmd    <= go & (ctype == CT_PSPACE);
			printer_memory_clear <= t_fire[T_INIT];
			if (go) begin
				ctype_r <= ctype;
				unique case (ctype)
					CT_PRINT:   printer_data <= {1'b0, buf_r[5:0]};
					CT_SPACE,
					CT_PSPACE:  printer_data <= {4'h0, buf_r[2:0]};
					CT_HTAB:    printer_data <= `LPCS_SPACE_CODE;
					CT_ILLEGAL: printer_data <= printer_data;
				endcase
			end
		end
	end

	// Interrupt requests on the assigned channels
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_channel_req <= 7'h00;
		else
			irq_channel_req <= chan_line(st_r.irq_a, st_r.done)
				| chan_line(st_r.irq_b, st_r.err_en & fault_s);
	end

endmodule : lpcs_sequencer

// ### sim/lpcs_monitor.sv
// Port checker for the line printer character sequencer.
// Assumes binding into lpcs_sequencer; one clock, synchronous active-low reset.
`timescale 1ns/100ps

module lpcs_monitor #(
	parameter int CLK_MHZ = 50
) (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic [3:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Printer side
	input wire logic        printer_ready,
	input wire logic [6:0]  printer_data,
	input wire logic        printer_strobe,
	input wire logic        printer_space_cmd,
	input wire logic        printer_print_cmd,
	input wire logic        printer_memory_clear
);
	// Memory clear trails the init write by the 1 us delay plus one register stage
	localparam int CLR_DLY = CLK_MHZ + 1;
	logic init_wr;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Init request taken this cycle; partial strobes change nothing, so excluded
	assign init_wr = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_awaddr == 4'h0
		&& s_axi_wstrb == 4'hF && s_axi_wdata[9];

	// Bus answers and their holding
	property p_wr_ans; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_rd_ans; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");

	// Printer timing and pulse shape
	property p_init_clr; init_wr |-> ##CLR_DLY printer_memory_clear; endproperty
	a_init_clr: assert property (p_init_clr) else $error("memory clear late or missing");
	property p_pulse; printer_strobe || printer_memory_clear |=> !printer_strobe && !printer_memory_clear; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse wider than one cycle");
	property p_go_rdy; printer_space_cmd || printer_print_cmd |-> $past(printer_ready, 2); endproperty
	a_go_rdy: assert property (p_go_rdy) else $error("command while printer not ready");
	property p_strb_dat; printer_strobe |-> $stable(printer_data) && !printer_data[6]; endproperty
	a_strb_dat: assert property (p_strb_dat) else $error("strobe data unsettled");

	// Main scenarios reached
	c_clr: cover property (printer_memory_clear);
	c_strobe: cover property (printer_strobe);
	c_space: cover property (printer_space_cmd);
	c_print: cover property (printer_print_cmd);
endmodule : lpcs_monitor

bind lpcs_sequencer lpcs_monitor #(.CLK_MHZ(CLK_MHZ)) mon_u (
	.aclk                 (aclk),
	.aresetn              (aresetn),
	.s_axi_awaddr         (s_axi_awaddr),
	.s_axi_awvalid        (s_axi_awvalid),
	.s_axi_wdata          (s_axi_wdata),
	.s_axi_wstrb          (s_axi_wstrb),
	.s_axi_wvalid         (s_axi_wvalid),
	.s_axi_bresp          (s_axi_bresp),
	.s_axi_bvalid         (s_axi_bvalid),
	.s_axi_bready         (s_axi_bready),
	.s_axi_arvalid        (s_axi_arvalid),
	.s_axi_rdata          (s_axi_rdata),
	.s_axi_rvalid         (s_axi_rvalid),
	.s_axi_rready         (s_axi_rready),
	.printer_ready        (printer_ready),
	.printer_data         (printer_data),
	.printer_strobe       (printer_strobe),
	.printer_space_cmd    (printer_space_cmd),
	.printer_print_cmd    (printer_print_cmd),
	.printer_memory_clear (printer_memory_clear)
);

// ### sim/lpcs_printer_model.sv
// Behavioural printer mechanism facing the sequencer.
// Assumes the sequencer clock; slow picks a long mechanism busy time.
`timescale 1ns/100ps

module lpcs_printer_model (
	// Clock, reset and pace
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic slow,
	// Commands from the sequencer
	input wire logic printer_strobe,
	input wire logic printer_space_cmd,
	input wire logic printer_print_cmd,
	input wire logic printer_memory_clear,
	// Ready level back
	output logic     printer_ready
);
	int busy_n;

	// Ready drops at every command and only returns after the busy time, never early
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			printer_ready <= 1'b0;
			busy_n <= 0;
		end else if (printer_strobe || printer_space_cmd || printer_print_cmd
			|| printer_memory_clear) begin
			printer_ready <= 1'b0;
			busy_n <= slow ? 400 : 8;
		end else if (busy_n > 1) begin
			busy_n <= busy_n - 1;
		end else if (busy_n == 1) begin
			printer_ready <= 1'b1;
			busy_n <= 0;
		end
	end
endmodule : lpcs_printer_model

// ### sim/lpcs_sequencer_tb.sv
// Self-checking bench for the line printer character sequencer.
// Assumes the bound port checker and the behavioural printer model.
`timescale 1ns/100ps

module lpcs_sequencer_tb;
	logic        aclk, aresetn, slow, printer_ready, printer_fault, printer_strobe;
	logic        printer_space_cmd, printer_print_cmd, printer_memory_clear;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
	logic [6:0]  printer_data;
	logic [7:1]  irq_channel_req;
	logic [7:0]  ev[$];
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          mclr_n = 0;

	lpcs_sequencer #(.CLK_MHZ(50)) dut_u (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.s_axi_awaddr         (s_axi_awaddr),
		.s_axi_awvalid        (s_axi_awvalid),
		.s_axi_awready        (s_axi_awready),
		.s_axi_wdata          (s_axi_wdata),
		.s_axi_wstrb          (s_axi_wstrb),
		.s_axi_wvalid         (s_axi_wvalid),
		.s_axi_wready         (s_axi_wready),
		.s_axi_bresp          (s_axi_bresp),
		.s_axi_bvalid         (s_axi_bvalid),
		.s_axi_bready         (s_axi_bready),
		.s_axi_araddr         (s_axi_araddr),
		.s_axi_arvalid        (s_axi_arvalid),
		.s_axi_arready        (s_axi_arready),
		.s_axi_rdata          (s_axi_rdata),
		.s_axi_rresp          (s_axi_rresp),
		.s_axi_rvalid         (s_axi_rvalid),
		.s_axi_rready         (s_axi_rready),
		.printer_ready        (printer_ready),
		.printer_fault        (printer_fault),
		.printer_data         (printer_data),
		.printer_strobe       (printer_strobe),
		.printer_space_cmd    (printer_space_cmd),
		.printer_print_cmd    (printer_print_cmd),
		.printer_memory_clear (printer_memory_clear),
		.irq_channel_req      (irq_channel_req)
	);
	lpcs_printer_model prn_u (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.slow                 (slow),
		.printer_strobe       (printer_strobe),
		.printer_space_cmd    (printer_space_cmd),
		.printer_print_cmd    (printer_print_cmd),
		.printer_memory_clear (printer_memory_clear),
		.printer_ready        (printer_ready)
	);

	// 50 MHz clock
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// Printer traffic in order: strobe data, space data with bit 7 set, print as FF
	always @(posedge aclk) begin
		if (printer_strobe) ev.push_back({1'b0, printer_data});
		if (printer_space_cmd) ev.push_back({1'b1, printer_data});
		if (printer_print_cmd) ev.push_back(8'hFF);
		if (printer_memory_clear) mclr_n++;
	end

	task automatic conclude();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic hang();
		error_cnt++;
		$display("[FAIL] %0t wait timed out", $time);
		conclude();
	endtask : hang

	// Sampled at the falling edge so the combinational readies are settled
	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (s !== 1'b1 && n < 100);
		if (s !== 1'b1) hang();
	endtask : wait_hi

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		wait_hi(s_axi_awready);
		@(posedge aclk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		wait_hi(s_axi_bvalid);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		wait_hi(s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		wait_hi(s_axi_rvalid);
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		axi_rd(a);
		chk(rd_d, e);
	endtask : rc

	task automatic poll_done();
		int n;
		n = 0;
		do begin
			axi_rd(4'h0);
			n++;
		end while (rd_d[6] !== 1'b1 && n < 4000);
		if (rd_d[6] !== 1'b1) hang();
	endtask : poll_done

	// Upper bits staged first, the low word starts the data-out
	task automatic t_load(input logic [34:0] b);
		ev.delete();
		axi_wr(4'h8, {29'h0, b[34:32]}, 4'hF, 2'h0);
		axi_wr(4'h4, b[31:0], 4'hF, 2'h0);
	endtask : t_load

	task automatic t_regs();
		rc(4'h0, 32'h0);
		rc(4'hC, 32'h0);
		axi_wr(4'h0, 32'h7, 4'h1, 2'h0);
		rc(4'h0, 32'h0);
		axi_wr(4'hC, 32'h1, 4'hF, 2'h2);
		axi_rd(4'h2);
		chk({30'h0, rd_r}, 32'h2);
	endtask : t_regs

	// Init with channels 3 and 5; the slow printer keeps ready low a long time
	task automatic t_init();
		slow <= 1'b1;
		axi_wr(4'h0, 32'h32B, 4'hF, 2'h0);
		rc(4'h0, 32'h12B);
		repeat (60) @(posedge aclk);
		rc(4'h0, 32'h1AB);
		rc(4'hC, 32'h11000);
		poll_done();
		chk(rd_d, 32'h16B);
		chk({25'h0, irq_channel_req}, 32'h4);
		// Printer error with its enable set adds a request on the second channel field
		printer_fault <= 1'b1;
		repeat (5) @(negedge aclk);
		chk({25'h0, irq_channel_req}, 32'h14);
		@(posedge aclk);
		printer_fault <= 1'b0;
		rc(4'hC, 32'h30000);
		chk(mclr_n, 32'h1);
	endtask : t_init

	task automatic t_print();
		slow <= 1'b0;
		t_load({7'h45, 7'h44, 7'h43, 7'h42, 7'h41});
		rc(4'hC, 32'h20C00);
		rc(4'h0, 32'h1AB);
		poll_done();
		chk({25'h0, irq_channel_req}, 32'h4);
		rc(4'hC, 32'h30205);
		rc(4'h4, 32'h58B162C5);
		chk(ev.size(), 32'h5);
		for (int i = 0; i < 5; i++) chk({24'h0, ev[i]}, 32'(i + 1));
	endtask : t_print

	// Space, print-space, illegal, tab from column 0, then one printing char
	task automatic t_mixed();
		logic [7:0] e[$];
		e = {8'h81, 8'hFF};
		repeat (8) e.push_back(8'h20);
		e.push_back(8'h01);
		slow <= 1'b1;
		axi_wr(4'h0, 32'h0, 4'hF, 2'h0);
		rc(4'h0, 32'h0);
		t_load({7'h41, 7'h09, 7'h00, 7'h0B, 7'h11});
		poll_done();
		chk(rd_d, 32'h40);
		chk({25'h0, irq_channel_req}, 32'h0);
		axi_rd(4'hC);
		chk(rd_d & 32'h1FFFF, 32'h10209);
		chk(ev.size(), 32'hB);
		for (int i = 0; i < 11; i++) chk({24'h0, ev[i]}, {24'h0, e[i]});
	endtask : t_mixed

	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_wstrb, s_axi_araddr} = 12'h000;
		s_axi_wdata = 32'h0;
		printer_fault = 1'b0;
		slow = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_init();
		t_print();
		t_mixed();
		conclude();
	end
endmodule : lpcs_sequencer_tb
